// *** logic/cbl_loader.sv ***
// card backup and startup loader: sequences startup transfers, switch
// backup/restore/compare, online replacement, file instructions and
// corrupt file cleanup; drives the card power indicator
// assumes a file engine outside that does the actual media work
//
// Contract
// - pin 2 on, backup pin off at power-on: auto load program, params, memory
// - pin 7 on overrides startup transfer; pins 7 and 8 must be off
// - replacement variant loads program and memory, never parameters
// - replacement starts on rising edge of start bit A65015
// - pin 7 on, switch held three seconds: back up to card
// - pin 7 on with backup card at power-on: restore from card
// - pin 7 off, switch held three seconds: compare with card
// - success of backup or restore: flash once then off
// - compare match: flash once then off
// - card present: symbol and comment transfers use the card only
// - file area starts at configured bank and must be initialised
// - file write stores memory range as named file on a medium
// - file read copies a named file into data memory
// - network commands to self also run card file operations
// - power lost mid access: delete affected file at next power-on; with both cut, only the card file is deleted
// - deletion sets card flag bit 7 or area flag bit 6
// - deletion flag stays on until power is next turned off
// - deletion writes a log file in the media root
// - indicator flashes once, stays lit during transfer, off when done; code does this for backup, restore and compare only
`timescale 1ns/1ps
module cbl_loader #(
    parameter int unsigned HOLD_CYC  = cbl_pkg::HOLD_CYC,
    parameter int unsigned FLASH_CYC = cbl_pkg::FLASH_CYC
) (
    input  wire logic        CORE_CLK_I,       // 100 MHz clock
    input  wire logic        RST_I,            // power-on reset, high
    input  wire logic        SW_AUTO_I,        // switch pin 2
    input  wire logic        SW_BACKUP_I,      // switch pin 7
    input  wire logic        SW_PIN8_I,        // switch pin 8
    input  wire logic        CARD_PRESENT_I,   // card inserted
    input  wire logic        CARD_INIT_I,      // card initialised
    input  wire logic        CARD_HAS_PARAM_I, // parameter file present
    input  wire logic        CARD_PWR_SW_I,    // card power switch
    input  wire logic        EM_ENABLE_I,      // file area configured
    input  wire logic        EM_INIT_I,        // file area initialised
    input  wire logic [3:0]  EM_BANK_I,        // file area start bank
    input  wire logic        DIRTY_CARD_I,     // card access cut by loss
    input  wire logic        DIRTY_EM_I,       // area access cut by loss
    input  wire logic        MEM_WE_I,         // special word write
    input  wire logic [15:0] MEM_ADDR_I,       // special word address
    input  wire logic [15:0] MEM_WDATA_I,      // special word data
    input  wire logic        FWRITE_I,         // file write instruction
    input  wire logic        FREAD_I,          // file read instruction
    input  wire logic        NET_CMD_I,        // command to self
    input  wire logic        NET_WRITE_I,      // command is a write
    input  wire logic        FILE_EM_I,        // target the file area
    input  wire logic        SYMBOL_I,         // symbol/comment transfer
    input  wire logic        ENG_DONE_I,       // engine finished
    input  wire logic        ENG_OK_I,         // engine result good
    output logic             ENG_START_O,      // engine start pulse
    output logic [3:0]       ENG_OP_O,         // engine operation
    output logic             ENG_EM_O,         // engine medium: area
    output logic [3:0]       ENG_BANK_O,       // area start bank
    output logic             ENG_LOG_O,        // write deletion log
    output logic [15:0]      ENG_NAME_O,       // file name word
    output logic             ENG_BUSY_O,       // operation in progress
    output logic             CARD_IND_O,       // card power indicator
    output logic             DEL_CARD_O,       // card deletion flag
    output logic             DEL_EM_O,         // area deletion flag
    output logic             ERR_O             // last operation failed
);
    initial if (FLASH_CYC < 1) $error("flash too short");
    // ------------------------------------------------------------------
    // local signals
    // ------------------------------------------------------------------
    cbl_pkg::cbl_state_t state;
    logic        hold_fire;
    logic [15:0] pw;
    logic        start_bit;
    logic        start_req;
    logic        boot_pend;
    logic        del_pend;
    logic [31:0] fcnt;
    logic [1:0]  name_idx;
    logic        name_we;
    logic [15:0] name_word;
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic card_ok(input logic p, input logic i);
        return p & i;
    endfunction
    cbl_hold_timer #(.HOLD(HOLD_CYC)) u_hold (
        .clk_i   (CORE_CLK_I),
        .rst_i   (RST_I),
        .level_i (CARD_PWR_SW_I),
        .fire_o  (hold_fire)
    );
    assign name_we = MEM_WE_I && MEM_ADDR_I >= cbl_pkg::NAME_WORD0
                     && MEM_ADDR_I <= cbl_pkg::NAME_WORD3;
    cbl_name_mem u_name (
        .clk_i   (CORE_CLK_I),
        .we_i    (name_we),
        .waddr_i (MEM_ADDR_I[1:0] - 2'h0),
        .wdata_i (MEM_WDATA_I),
        .raddr_i (name_idx),
        .rdata_o (name_word)
    );
    // ------------------------------------------------------------------
    // special words: password and start bit edge
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pw        <= 16'h0000;
            start_bit <= 1'b0;
            start_req <= 1'b0;
        end else begin
            if (MEM_WE_I && MEM_ADDR_I == cbl_pkg::PW_WORD) begin
                pw <= MEM_WDATA_I;
            end
            if (MEM_WE_I && MEM_ADDR_I == cbl_pkg::START_WORD) begin
                start_bit <= MEM_WDATA_I[cbl_pkg::START_BIT];
                if (MEM_WDATA_I[cbl_pkg::START_BIT] && !start_bit) begin
                    start_req <= 1'b1;
                end
            end
            if (start_req && state == cbl_pkg::CBL_S_IDLE) begin
                start_req <= 1'b0;
            end
        end
    end
    // ------------------------------------------------------------------
    // deletion flags: set at power-on cleanup, cleared only by power-off
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            DEL_CARD_O <= 1'b0;
            DEL_EM_O   <= 1'b0;
        end else if (del_pend && state == cbl_pkg::CBL_S_IDLE) begin
            DEL_CARD_O <= DEL_CARD_O | DIRTY_CARD_I;
            DEL_EM_O   <= DEL_EM_O | DIRTY_EM_I;
        end
    end
    // ------------------------------------------------------------------
    // main sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state       <= cbl_pkg::CBL_S_IDLE;
            boot_pend   <= 1'b1;
            del_pend    <= 1'b1;
            fcnt        <= 32'h0;
            name_idx    <= 2'h0;
            ENG_START_O <= 1'b0;
            ENG_OP_O    <= cbl_pkg::CBL_OP_NONE;
            ENG_EM_O    <= 1'b0;
            ENG_BANK_O  <= 4'h0;
            ENG_LOG_O   <= 1'b0;
            ENG_NAME_O  <= 16'h0000;
            ENG_BUSY_O  <= 1'b0;
            CARD_IND_O  <= 1'b0;
            ERR_O       <= 1'b0;
        end else begin
            ENG_START_O <= 1'b0;
            ENG_LOG_O   <= 1'b0;
            ENG_BANK_O  <= EM_BANK_I;
            ENG_NAME_O  <= name_word;
            name_idx    <= name_idx + 2'h1;
            case (state)
            cbl_pkg::CBL_S_IDLE: begin
                ENG_BUSY_O <= 1'b0;
                if (del_pend) begin
                    del_pend <= 1'b0;
                    if (DIRTY_CARD_I || DIRTY_EM_I) begin
                        ENG_OP_O    <= cbl_pkg::CBL_OP_DELETE;
                        ENG_EM_O    <= !DIRTY_CARD_I;
                        ENG_LOG_O   <= 1'b1;
                        ENG_START_O <= 1'b1;
                        ENG_BUSY_O  <= 1'b1;
                        state       <= cbl_pkg::CBL_S_RUN;
                    end
                end else if (boot_pend) begin
                    boot_pend <= 1'b0;
                    if (SW_BACKUP_I && card_ok(CARD_PRESENT_I,
                                               CARD_INIT_I)) begin
                        ENG_OP_O   <= cbl_pkg::CBL_OP_RESTORE;
                        ENG_EM_O   <= 1'b0;
                        ENG_BUSY_O <= 1'b1;
                        fcnt       <= 32'h0;
                        CARD_IND_O <= 1'b1;
                        state      <= cbl_pkg::CBL_S_FLASH;
                    end else if (SW_AUTO_I && !SW_BACKUP_I && !SW_PIN8_I
                                 && card_ok(CARD_PRESENT_I,
                                            CARD_INIT_I)) begin
                        // parameters only in the full variant
                        ENG_OP_O    <= CARD_HAS_PARAM_I
                                       ? cbl_pkg::CBL_OP_AUTO
                                       : cbl_pkg::CBL_OP_REPL;
                        ENG_EM_O    <= 1'b0;
                        ENG_START_O <= 1'b1;
                        ENG_BUSY_O  <= 1'b1;
                        state       <= cbl_pkg::CBL_S_RUN;
                    end
                end else if (hold_fire) begin
                    if (!card_ok(CARD_PRESENT_I, CARD_INIT_I)) begin
                        ERR_O      <= 1'b1;
                        fcnt       <= 32'h0;
                        CARD_IND_O <= 1'b1;
                        state      <= cbl_pkg::CBL_S_FAIL;
                    end else begin
                        ENG_OP_O   <= SW_BACKUP_I
                                      ? cbl_pkg::CBL_OP_BACKUP
                                      : cbl_pkg::CBL_OP_COMPARE;
                        ENG_EM_O   <= 1'b0;
                        ENG_BUSY_O <= 1'b1;
                        fcnt       <= 32'h0;
                        CARD_IND_O <= 1'b1;
                        state      <= cbl_pkg::CBL_S_FLASH;
                    end
                end else if (start_req && pw == cbl_pkg::PASSWORD
                             && card_ok(CARD_PRESENT_I, CARD_INIT_I)) begin
                    ENG_OP_O    <= cbl_pkg::CBL_OP_ONLINE;
                    ENG_EM_O    <= 1'b0;
                    ENG_START_O <= 1'b1;
                    ENG_BUSY_O  <= 1'b1;
                    state       <= cbl_pkg::CBL_S_RUN;
                end else if (FWRITE_I || FREAD_I || NET_CMD_I) begin
                    ENG_OP_O    <= (FWRITE_I || (NET_CMD_I && NET_WRITE_I))
                                   ? cbl_pkg::CBL_OP_FWRITE
                                   : cbl_pkg::CBL_OP_FREAD;
                    ENG_EM_O    <= FILE_EM_I && EM_ENABLE_I
                                   && EM_INIT_I;
                    ENG_START_O <= 1'b1;
                    ENG_BUSY_O  <= 1'b1;
                    state       <= cbl_pkg::CBL_S_RUN;
                end else if (SYMBOL_I) begin
                    ENG_OP_O    <= cbl_pkg::CBL_OP_SYMBOL;
                    ENG_EM_O    <= !CARD_PRESENT_I;
                    ENG_START_O <= 1'b1;
                    ENG_BUSY_O  <= 1'b1;
                    state       <= cbl_pkg::CBL_S_RUN;
                end
            end
            cbl_pkg::CBL_S_FLASH: begin
                // one flash: lit, dark, then lit for the transfer
                fcnt <= fcnt + 32'h1;
                if (fcnt == FLASH_CYC - 1) begin
                    CARD_IND_O <= 1'b0;
                end else if (fcnt == 2 * FLASH_CYC - 1) begin
                    CARD_IND_O  <= 1'b1;
                    ENG_START_O <= 1'b1;
                    state       <= cbl_pkg::CBL_S_RUN;
                end
            end
            cbl_pkg::CBL_S_RUN: begin
                if (ENG_DONE_I) begin
                    ERR_O <= !ENG_OK_I;
                    fcnt  <= 32'h0;
                    if (ENG_OK_I) begin
                        CARD_IND_O <= 1'b0;
                        state      <= cbl_pkg::CBL_S_IDLE;
                    end else begin
                        CARD_IND_O <= 1'b1;
                        state      <= cbl_pkg::CBL_S_FAIL;
                    end
                end
            end
            cbl_pkg::CBL_S_FAIL: begin
                // failure: indicator blinks until the switch is released
                fcnt <= fcnt + 32'h1;
                if (fcnt == FLASH_CYC - 1) begin
                    fcnt       <= 32'h0;
                    CARD_IND_O <= !CARD_IND_O;
                end
                if (!CARD_PWR_SW_I && CARD_IND_O
                    && fcnt == FLASH_CYC - 1) begin
                    state <= cbl_pkg::CBL_S_DONE;
                end
            end
            default: begin
                CARD_IND_O <= 1'b0;
                ENG_BUSY_O <= 1'b0;
                state      <= cbl_pkg::CBL_S_IDLE;
            end
            endcase
        end
    end
    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_flag_sticky;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        $rose(DEL_CARD_O) |=> DEL_CARD_O [*8];
    endproperty
    a_flag_sticky : assert property (p_flag_sticky)
        else $error("card deletion flag dropped");
    property p_no_param;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (ENG_START_O && !CARD_HAS_PARAM_I && boot_pend == 1'b0
         && $past(boot_pend)) |-> ENG_OP_O != cbl_pkg::CBL_OP_AUTO;
    endproperty
    a_no_param : assert property (p_no_param)
        else $error("parameters loaded without parameter file");
    property p_symbol_card;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (state == cbl_pkg::CBL_S_IDLE && !del_pend && !boot_pend
         && !hold_fire && !start_req && !FWRITE_I && !FREAD_I
         && !NET_CMD_I && SYMBOL_I && CARD_PRESENT_I)
        |=> ENG_START_O && !ENG_EM_O;
    endproperty
    a_symbol_card : assert property (p_symbol_card)
        else $error("symbol transfer left the card");
    property p_ok_dark;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (state == cbl_pkg::CBL_S_RUN && ENG_DONE_I && ENG_OK_I)
        |=> !CARD_IND_O && !ERR_O;
    endproperty
    a_ok_dark : assert property (p_ok_dark)
        else $error("indicator lit after success");
    property p_lit_run;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (state == cbl_pkg::CBL_S_RUN
         && (ENG_OP_O == cbl_pkg::CBL_OP_BACKUP
             || ENG_OP_O == cbl_pkg::CBL_OP_RESTORE
             || ENG_OP_O == cbl_pkg::CBL_OP_COMPARE)) |-> CARD_IND_O;
    endproperty
    a_lit_run : assert property (p_lit_run)
        else $error("indicator dark during transfer");
    property p_flash_lit;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (state == cbl_pkg::CBL_S_FLASH && fcnt == 2 * FLASH_CYC - 1)
        |=> CARD_IND_O && state == cbl_pkg::CBL_S_RUN;
    endproperty
    a_flash_lit : assert property (p_flash_lit)
        else $error("indicator not lit for transfer");
    property p_nocard;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (state == cbl_pkg::CBL_S_IDLE && !del_pend && !boot_pend
         && hold_fire && !CARD_PRESENT_I)
        |=> ERR_O && state == cbl_pkg::CBL_S_FAIL && !ENG_START_O;
    endproperty
    a_nocard : assert property (p_nocard)
        else $error("switch request ran without card");
    property p_online;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (ENG_START_O && ENG_OP_O == cbl_pkg::CBL_OP_ONLINE)
        |-> $past(pw) == cbl_pkg::PASSWORD;
    endproperty
    a_online : assert property (p_online)
        else $error("replacement without password");
    property p_compare;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (state == cbl_pkg::CBL_S_IDLE && !del_pend && !boot_pend
         && hold_fire && !SW_BACKUP_I && CARD_PRESENT_I && CARD_INIT_I)
        |=> ENG_OP_O == cbl_pkg::CBL_OP_COMPARE && CARD_IND_O;
    endproperty
    a_compare : assert property (p_compare)
        else $error("compare not selected");
    property p_backup;
        @(posedge CORE_CLK_I) disable iff (RST_I)
        (state == cbl_pkg::CBL_S_IDLE && !del_pend && !boot_pend
         && hold_fire && SW_BACKUP_I && CARD_PRESENT_I && CARD_INIT_I)
        |=> ENG_OP_O == cbl_pkg::CBL_OP_BACKUP;
    endproperty
    a_backup : assert property (p_backup)
        else $error("backup not selected");
endmodule // cbl_loader

// *** logic/cbl_pkg.sv ***
// package of constants for the card backup and startup loader
// assumes a single 100 MHz core clock
package cbl_pkg;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 100000000;
    localparam int unsigned HOLD_MS     = 3000;      // switch hold time
    localparam int unsigned HOLD_CYC    = (CLK_HZ / 1000) * HOLD_MS;
    localparam int unsigned FLASH_MS    = 200;       // one flash length
    localparam int unsigned FLASH_CYC   = (CLK_HZ / 1000) * FLASH_MS;
    // ------------------------------------------------------------------
    // special memory words and bits
    // ------------------------------------------------------------------
    localparam logic [15:0] PASSWORD    = 16'hA5A5;
    localparam logic [15:0] PW_WORD     = 16'hA651;
    localparam logic [15:0] NAME_WORD0  = 16'hA654;
    localparam logic [15:0] NAME_WORD3  = 16'hA657;
    localparam logic [15:0] START_WORD  = 16'hA650;
    localparam int unsigned START_BIT   = 15;
    localparam int unsigned DEL_CARD_BIT = 7;        // word A395 bit 07
    localparam int unsigned DEL_EM_BIT  = 6;         // word A395 bit 06
    // ------------------------------------------------------------------
    // operation codes sent to the file engine
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CBL_OP_NONE    = 4'h0,
        CBL_OP_AUTO    = 4'h1,   // program, parameters, data memory
        CBL_OP_REPL    = 4'h2,   // program and data memory only
        CBL_OP_BACKUP  = 4'h3,
        CBL_OP_RESTORE = 4'h4,
        CBL_OP_COMPARE = 4'h5,
        CBL_OP_ONLINE  = 4'h6,   // online program replacement
        CBL_OP_FWRITE  = 4'h7,
        CBL_OP_FREAD   = 4'h8,
        CBL_OP_DELETE  = 4'h9,   // delete corrupt file, write log
        CBL_OP_SYMBOL  = 4'hA    // symbol table or comment transfer
    } cbl_op_t;
    typedef enum logic [2:0] {
        CBL_S_IDLE  = 3'b000,
        CBL_S_FLASH = 3'b001,
        CBL_S_RUN   = 3'b010,
        CBL_S_FAIL  = 3'b011,
        CBL_S_DONE  = 3'b100
    } cbl_state_t;
endpackage

// *** logic/cbl_hold_timer.sv ***
// counts how long a level has been held and pulses once at the limit
// assumes the level is synchronous to the clock
`timescale 1ns/1ps
module cbl_hold_timer #(
    parameter int unsigned HOLD = cbl_pkg::HOLD_CYC
) (
    input  wire logic clk_i,    // core clock
    input  wire logic rst_i,    // async reset, high
    input  wire logic level_i,  // held level
    output logic      fire_o    // one cycle pulse at the limit
);
    initial if (HOLD < 2) $error("hold too short");
    logic [31:0] cnt;
    // counter stops at the limit until the level drops
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt    <= 32'h0;
            fire_o <= 1'b0;
        end else begin
            fire_o <= 1'b0;
            if (!level_i) begin
                cnt <= 32'h0;
            end else if (cnt < HOLD) begin
                cnt <= cnt + 32'h1;
                if (cnt == HOLD - 1) begin
                    fire_o <= 1'b1;
                end
            end
        end
    end
endmodule // cbl_hold_timer

// *** logic/cbl_name_mem.sv ***
// four word store for the replacement program file name
// read data is registered
`timescale 1ns/1ps
module cbl_name_mem #(
    parameter int DEPTH = 4
) (
    input  wire logic        clk_i,    // core clock
    input  wire logic        we_i,     // write enable
    input  wire logic [1:0]  waddr_i,  // write index
    input  wire logic [15:0] wdata_i,  // write word
    input  wire logic [1:0]  raddr_i,  // read index
    output logic      [15:0] rdata_o   // registered read word
);
    initial if (DEPTH != 4) $error("depth must be four");
    logic [15:0] mem [DEPTH];
    // synchronous write and registered read
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule // cbl_name_mem

// *** dv/cbl_card_model.sv ***
// file engine and card model: answers every start after a short delay
// assumes start is a one cycle pulse from the loader
`timescale 1ns/1ps
module cbl_card_model (
    input  wire logic clk_i,   // core clock
    input  wire logic start_i, // engine start pulse
    output logic      done_o,  // engine done pulse
    output logic      ok_o     // result, valid with done
);
    logic [3:0] cnt = 4'h0;
    // done four cycles after start; ok drops between answers
    always_ff @(posedge clk_i) begin
        cnt    <= start_i ? 4'h3 : ((cnt != 4'h0) ? cnt - 4'h1 : 4'h0);
        done_o <= (cnt == 4'h1);
        ok_o   <= (cnt == 4'h1);
    end
endmodule // cbl_card_model

// *** dv/tb_top.sv ***
// testbench for the card loader: power-on, switch and file operations
// assumes the card model answers every engine start
`timescale 1ns/1ps
module tb_top;
    logic        clk, rst, sw2, sw7, card, par, psw, dirty, we, fw, fr, fem;
    logic [15:0] addr, wd, name;
    logic        start, done, ok, busy, ind, delc, dele, lg, eem, err, s_em;
    logic        sw8, dem, net, netw, sym, s_lg;
    logic [3:0]  op, bank, s_bank;
    int          bad_count = 0, n_tests = 0, cyc = 0;
    cbl_loader #(.HOLD_CYC(20), .FLASH_CYC(4)) uut (.CORE_CLK_I(clk),
        .RST_I(rst), .SW_AUTO_I(sw2), .SW_BACKUP_I(sw7), .SW_PIN8_I(sw8),
        .CARD_PRESENT_I(card), .CARD_INIT_I(card), .CARD_HAS_PARAM_I(par),
        .CARD_PWR_SW_I(psw), .EM_ENABLE_I(1'b1), .EM_INIT_I(1'b1),
        .EM_BANK_I(4'h5), .DIRTY_CARD_I(dirty), .DIRTY_EM_I(dem),
        .MEM_WE_I(we), .MEM_ADDR_I(addr), .MEM_WDATA_I(wd), .FWRITE_I(fw),
        .FREAD_I(fr), .NET_CMD_I(net), .NET_WRITE_I(netw),
        .FILE_EM_I(fem), .SYMBOL_I(sym), .ENG_DONE_I(done), .ENG_OK_I(ok),
        .ENG_START_O(start), .ENG_OP_O(op), .ENG_EM_O(eem), .ENG_BANK_O(bank),
        .ENG_LOG_O(lg), .ENG_NAME_O(name), .ENG_BUSY_O(busy),
        .CARD_IND_O(ind), .DEL_CARD_O(delc), .DEL_EM_O(dele), .ERR_O(err));
    cbl_card_model card_model (.clk_i(clk), .start_i(start), .done_o(done),
        .ok_o(ok));
    // clock and cycle ceiling
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // wait for a start, check its op, then wait for and check done
    task automatic op_is(input logic [3:0] exp);
        int k;
        k = 0;
        while (start !== 1'b1 && k < 400) begin
            @(negedge clk);
            k++;
        end
        {s_lg, s_em, s_bank} = {lg, eem, bank};
        chk({15'h0, start}, 16'h1);
        chk({12'h0, op}, {12'h0, exp});
        while (done !== 1'b1 && k < 800) begin
            @(negedge clk);
            k++;
        end
        chk({15'h0, done}, 16'h1);
        @(negedge clk);
    endtask
    task automatic por(input logic a, b, c, d);
        @(negedge clk);
        {rst, sw2, sw7, par, dirty, dem} = {1'b1, a, b, c, d, d};
        repeat (6) @(negedge clk);
        rst = 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        {we, addr, wd} = {1'b1, a, d};
        @(negedge clk);
        we = 1'b0;
    endtask
    task automatic pulse_req(input logic w, input logic e);
        {fw, fr, fem} = {w, ~w, e};
        @(negedge clk);
        {fw, fr} = 2'b00;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {rst, sw2, sw7, sw8, card, par, psw, dirty, dem, we, fw, fr, fem, net,
            netw, sym} = 16'h8800;
        {addr, wd} = 32'h0;
        por(1, 0, 1, 1);
        op_is(cbl_pkg::CBL_OP_DELETE);
        chk({14'h0, delc, dele}, 16'h3);
        chk({14'h0, s_lg, s_em}, 16'h2);
        op_is(cbl_pkg::CBL_OP_AUTO);
        chk({15'h0, delc}, 16'h1);
        por(1, 0, 0, 0);
        op_is(cbl_pkg::CBL_OP_REPL);
        chk({15'h0, delc}, 16'h0);
        sw8 = 1'b1;
        por(1, 0, 1, 0);
        repeat (10) @(negedge clk);
        chk({12'h0, op}, 16'h0);
        sw8 = 1'b0;
        por(1, 1, 1, 0);
        op_is(cbl_pkg::CBL_OP_RESTORE);
        chk({15'h0, ind}, 16'h0);
        psw = 1'b1;
        op_is(cbl_pkg::CBL_OP_BACKUP);
        chk({15'h0, ind}, 16'h0);
        {psw, sw7} = 2'b00;
        @(negedge clk);
        psw = 1'b1;
        op_is(cbl_pkg::CBL_OP_COMPARE);
        chk({15'h0, ind}, 16'h0);
        psw = 1'b0;
        wr(16'hA651, 16'hA5A5);
        wr(16'hA654, 16'h4142);
        repeat (8) if (name !== 16'h4142) @(negedge clk);
        chk(name, 16'h4142);
        wr(16'hA650, 16'h8000);
        op_is(cbl_pkg::CBL_OP_ONLINE);
        pulse_req(1'b1, 1'b1);
        op_is(cbl_pkg::CBL_OP_FWRITE);
        chk({11'h0, s_em, s_bank}, 16'h15);
        pulse_req(1'b0, 1'b0);
        op_is(cbl_pkg::CBL_OP_FREAD);
        chk({15'h0, s_em}, 16'h0);
        {net, netw} = 2'b11;
        @(negedge clk);
        net = 1'b0;
        op_is(cbl_pkg::CBL_OP_FWRITE);
        sym = 1'b1;
        @(negedge clk);
        sym = 1'b0;
        op_is(cbl_pkg::CBL_OP_SYMBOL);
        chk({15'h0, s_em}, 16'h0);
        {card, sw7, psw} = 3'b011;
        repeat (40) @(negedge clk);
        chk({15'h0, err}, 16'h1);
        summarize();
    end
endmodule // tb_top
